// *** design/ouhbp_host_port.sv ***
// host parallel bus port with per-channel byte buffers and shared interrupt
// Notes on behaviour
// - low four address bits pick a channel register: data 0, tx level E, rx level F; other indices read zero.
// - address bits four to six give the channel number, zero to seven.
// - top address bit switches the access to the global register space.
// - eight-bit data bus, driven on reads, sampled on writes.
// - strap high: read strobe falling starts read, byte presented on bus.
// - strap high: write starts at strobe fall, data stored at strobe rise.
// - strap high: accesses answered only while chip select is low.
// - strap low: write strobe pin is direction, high read, low write.
// - strap low: chip select pin is the single low strobe for both.
// - one open-drain low interrupt output covers all channels.
// - global interrupt source register shows all eight channels at once.
// - each channel has 64-byte transmit and receive buffers with levels.
module ouhbp_host_port #(
  parameter int NCH = ouhbp_pkg::NUM_CHAN,
  parameter int DEPTH = ouhbp_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic bus_style_strap,
  input wire logic [7:0] host_addr_lines,
  input wire logic [7:0] host_data_lines_in,
  output logic [7:0] host_data_lines_out,
  output logic host_data_lines_oe,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chip_sel_n,
  output logic irq_n_out,
  output logic irq_n_oe,
  input wire logic [NCH-1:0] chan_irq_pend,
  input wire logic [NCH-1:0] rx_push,
  input wire logic [NCH-1:0][7:0] rx_byte,
  input wire logic [NCH-1:0] tx_pop,
  output logic [NCH-1:0][7:0] tx_byte,
  output logic [NCH-1:0] tx_byte_valid
);
  localparam int PW = $clog2(DEPTH);
  localparam int LW = PW + 1;

  // pin synchroniser, stage one read only by stage two
  ouhbp_pkg::ouhbp_pins_t s1_reg, s1_next, s2_reg, s2_next;

  always_comb begin
    s1_next.addr = host_addr_lines;
    s1_next.data = host_data_lines_in;
    s1_next.rd_n = read_strobe_n;
    s1_next.wr_n = write_strobe_n;
    s1_next.cs_n = chip_sel_n;
    s1_next.strap = bus_style_strap;
    s2_next = s1_reg;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      s1_reg <= ouhbp_pkg::PINS_RST;
      s2_reg <= ouhbp_pkg::PINS_RST;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
    end
  end

  // qualified read and write phases per bus style
  logic rd_act, wr_act;

  always_comb begin
    if (s2_reg.strap) begin
      rd_act = !s2_reg.cs_n && !s2_reg.rd_n;
      wr_act = !s2_reg.cs_n && !s2_reg.wr_n;
    end else begin
      rd_act = !s2_reg.cs_n && s2_reg.wr_n;
      wr_act = !s2_reg.cs_n && !s2_reg.wr_n;
    end
  end

  // per-channel buffers, dir 0 transmit, dir 1 receive
  logic [NCH-1:0][1:0] f_push, f_pop, f_push_ok, f_pop_ok;
  logic [NCH-1:0][1:0][7:0] f_din, f_head;
  logic [NCH-1:0][1:0][LW-1:0] f_lvl;
  logic [NCH-1:0] host_push, host_pop;
  logic [7:0] wr_byte_reg, wr_byte_next;

  genvar c, d;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      assign f_push[c][ouhbp_pkg::DIR_TX] = host_push[c];
      assign f_din[c][ouhbp_pkg::DIR_TX] = wr_byte_reg;
      assign f_pop[c][ouhbp_pkg::DIR_TX] = tx_pop[c];
      assign f_push[c][ouhbp_pkg::DIR_RX] = rx_push[c];
      assign f_din[c][ouhbp_pkg::DIR_RX] = rx_byte[c];
      assign f_pop[c][ouhbp_pkg::DIR_RX] = host_pop[c];
      for (d = 0; d < 2; d++) begin : g_dir
        logic [DEPTH-1:0][7:0] mem_reg, mem_next;
        logic [PW-1:0] wp_reg, wp_next, rp_reg, rp_next;
        logic [LW-1:0] cnt_reg, cnt_next;

        always_comb begin
          f_push_ok[c][d] = f_push[c][d] && (cnt_reg < LW'(DEPTH));
          f_pop_ok[c][d] = f_pop[c][d] && (cnt_reg != '0);
          mem_next = mem_reg;
          wp_next = wp_reg;
          rp_next = rp_reg;
          cnt_next = cnt_reg;
          if (f_push_ok[c][d]) begin
            mem_next[wp_reg] = f_din[c][d];
            wp_next = PW'(wp_reg + 1'b1);
          end
          if (f_pop_ok[c][d]) begin
            rp_next = PW'(rp_reg + 1'b1);
          end
          if (f_push_ok[c][d] && !f_pop_ok[c][d]) begin
            cnt_next = LW'(cnt_reg + 1'b1);
          end else if (!f_push_ok[c][d] && f_pop_ok[c][d]) begin
            cnt_next = LW'(cnt_reg - 1'b1);
          end
          f_head[c][d] = (cnt_reg != '0) ? mem_reg[rp_reg] : ouhbp_pkg::BYTE_RST;
          f_lvl[c][d] = cnt_reg;
        end

        always_ff @(posedge core_clk) begin
          if (reset) begin
            mem_reg <= '0;
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
          end else begin
            mem_reg <= mem_next;
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
          end
        end
      end
    end
  endgenerate

  // transmit byte handed to the serial side one cycle after its pop
  logic [NCH-1:0][7:0] txb_reg, txb_next;
  logic [NCH-1:0] txv_reg, txv_next;

  always_comb begin
    txb_next = txb_reg;
    txv_next = '0;
    for (int i = 0; i < NCH; i++) begin
      if (f_pop_ok[i][ouhbp_pkg::DIR_TX]) begin
        txb_next[i] = f_head[i][ouhbp_pkg::DIR_TX];
        txv_next[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      txb_reg <= '0;
      txv_reg <= '0;
    end else begin
      txb_reg <= txb_next;
      txv_reg <= txv_next;
    end
  end

  assign tx_byte = txb_reg;
  assign tx_byte_valid = txv_reg;

  // read data selection from the decoded address
  ouhbp_pkg::ouhbp_addr_t a;
  logic [7:0] rd_byte;

  always_comb begin
    a = s2_reg.addr;
    rd_byte = ouhbp_pkg::RESV_READ;
    if (a.global_sel) begin
      if (a.idx == ouhbp_pkg::GIDX_IRQ_SRC) begin
        rd_byte = 8'(chan_irq_pend);
      end
    end else if (int'(a.chan) < NCH) begin
      case (a.idx)
        ouhbp_pkg::IDX_DATA: rd_byte = f_head[a.chan][ouhbp_pkg::DIR_RX];
        ouhbp_pkg::IDX_TX_LVL: rd_byte = 8'(f_lvl[a.chan][ouhbp_pkg::DIR_TX]);
        ouhbp_pkg::IDX_RX_LVL: rd_byte = 8'(f_lvl[a.chan][ouhbp_pkg::DIR_RX]);
        default: rd_byte = ouhbp_pkg::RESV_READ;
      endcase
    end
  end

  // bus transfer sequencer
  ouhbp_pkg::ouhbp_state_t st_reg, st_next;
  logic [7:0] dout_reg, dout_next;
  logic doe_reg, doe_next;
  logic ch_ok;

  always_comb begin
    st_next = st_reg;
    dout_next = dout_reg;
    doe_next = 1'b0;
    host_pop = '0;
    ch_ok = !a.global_sel && (int'(a.chan) < NCH) && (a.idx == ouhbp_pkg::IDX_DATA);
    case (st_reg)
      ouhbp_pkg::ST_IDLE: begin
        if (rd_act) begin
          st_next = ouhbp_pkg::ST_READ;
          dout_next = rd_byte;
          doe_next = 1'b1;
          if (ch_ok) begin
            host_pop[a.chan] = 1'b1;
          end
        end else if (wr_act) begin
          st_next = ouhbp_pkg::ST_WRITE;
        end
      end
      ouhbp_pkg::ST_READ: begin
        if (rd_act) begin
          doe_next = 1'b1;
        end else begin
          st_next = ouhbp_pkg::ST_IDLE;
        end
      end
      ouhbp_pkg::ST_WRITE: begin
        if (!wr_act) begin
          st_next = ouhbp_pkg::ST_IDLE;
        end
      end
      default: st_next = ouhbp_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_reg <= ouhbp_pkg::ST_IDLE;
      dout_reg <= ouhbp_pkg::DOUT_RST;
      doe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      dout_reg <= dout_next;
      doe_reg <= doe_next;
    end
  end

  assign host_data_lines_out = dout_reg;
  assign host_data_lines_oe = doe_reg;

  // write commit: byte and target latched at phase end, pushed next cycle
  // so the buffer always takes the freshly latched byte, never the old one
  logic wr_go_reg, wr_go_next;
  logic [2:0] wr_chan_reg, wr_chan_next;

  always_comb begin
    wr_byte_next = wr_byte_reg;
    wr_go_next = 1'b0;
    wr_chan_next = wr_chan_reg;
    if (st_reg == ouhbp_pkg::ST_WRITE && !wr_act) begin
      wr_byte_next = s2_reg.data;
      wr_go_next = ch_ok;
      wr_chan_next = a.chan;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_byte_reg <= ouhbp_pkg::BYTE_RST;
      wr_go_reg <= 1'b0;
      wr_chan_reg <= '0;
    end else begin
      wr_byte_reg <= wr_byte_next;
      wr_go_reg <= wr_go_next;
      wr_chan_reg <= wr_chan_next;
    end
  end

  always_comb begin
    host_push = '0;
    if (wr_go_reg) begin
      host_push[wr_chan_reg] = 1'b1;
    end
  end

  // open-drain interrupt: pull low while any channel is pending
  logic irq_oe_reg, irq_oe_next;
  logic irq_lvl_reg, irq_lvl_next;

  always_comb begin
    irq_oe_next = |chan_irq_pend;
    irq_lvl_next = 1'b0;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_oe_reg <= 1'b0;
      irq_lvl_reg <= 1'b0;
    end else begin
      irq_oe_reg <= irq_oe_next;
      irq_lvl_reg <= irq_lvl_next;
    end
  end

  assign irq_n_out = irq_lvl_reg;
  assign irq_n_oe = irq_oe_reg;
endmodule

// *** design/ouhbp_pkg.sv ***
// constants and carrier types of the octal uart host bus port
package ouhbp_pkg;
  localparam int NUM_CHAN = 8;
  localparam int FIFO_DEPTH = 64;
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_TX_LVL = 4'hE;
  localparam logic [3:0] IDX_RX_LVL = 4'hF;
  localparam logic [3:0] GIDX_IRQ_SRC = 4'h0;
  localparam logic [7:0] RESV_READ = 8'h00;
  localparam logic [7:0] DOUT_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam int DIR_TX = 0;
  localparam int DIR_RX = 1;

  typedef struct packed {
    logic global_sel;
    logic [2:0] chan;
    logic [3:0] idx;
  } ouhbp_addr_t;

  typedef struct packed {
    ouhbp_addr_t addr;
    logic [7:0] data;
    logic rd_n;
    logic wr_n;
    logic cs_n;
    logic strap;
  } ouhbp_pins_t;

  // strobes, chip select and strap idle high
  localparam ouhbp_pins_t PINS_RST = 20'h0000F;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_READ = 2'h1,
    ST_WRITE = 2'h2
  } ouhbp_state_t;
endpackage

// *** design/ouhbp_unused_guard.sv ***
// holds no logic: the whole port sits in ouhbp_host_port

// *** verification/ouhbp_host_model.sv ***
// host processor model on the parallel bus
module ouhbp_host_model (
  input wire logic clk,
  input wire logic strap,
  output logic [7:0] addr,
  output logic [7:0] bus,
  output logic rd_n,
  output logic wr_n,
  output logic cs_n,
  input wire logic [7:0] dev_out,
  input wire logic dev_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drv = 1'b0;
  logic [7:0] dat = 8'h00;
  logic [7:0] last = 8'h00;
  // floating bus toggles
  always_comb bus = dev_oe ? dev_out : (drv ? dat : ~last);
  always @(posedge clk) last <= bus;
  initial begin
    addr = 8'h00;
    {rd_n, wr_n, cs_n} = 3'h7;
  end
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge clk);
    addr = a;
    dat = d;
    drv = wr;
    cs_n = 1'b0;
    wr_n = !wr;
    rd_n = strap ? wr : 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    q = bus;
    {rd_n, wr_n, cs_n} = 3'h7;
    repeat (3) @(negedge clk);
    drv = 1'b0;
    repeat (3) @(negedge clk);
  endtask
endmodule

// *** verification/ouhbp_sva.sv ***
// assertions on the host bus port pins
module ouhbp_sva #(
  parameter int NCH = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic bus_style_strap,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic chip_sel_n,
  input wire logic [7:0] host_data_lines_out,
  input wire logic host_data_lines_oe,
  input wire logic irq_n_out,
  input wire logic irq_n_oe,
  input wire logic [NCH-1:0] chan_irq_pend,
  input wire logic [NCH-1:0] tx_pop,
  input wire logic [NCH-1:0] tx_byte_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_wr;
    (!chip_sel_n && !write_strobe_n)[*3];
  endsequence
  sequence s_rd;
    (bus_style_strap && !chip_sel_n && !read_strobe_n && write_strobe_n)[*5];
  endsequence
  sequence s_dir_rd;
    (!bus_style_strap && !chip_sel_n && write_strobe_n)[*5];
  endsequence
  AST_RD:
    assert property (s_rd |-> host_data_lines_oe) else $error("read not driven");
  AST_DIR_RD:
    assert property (s_dir_rd |-> host_data_lines_oe) else $error("dir read not driven");
  AST_WR_RELEASE:
    assert property (s_wr |-> !host_data_lines_oe) else $error("bus driven in write");
  AST_CS_GATE:
    assert property (chip_sel_n[*5] |-> !host_data_lines_oe) else $error("drive without cs");
  AST_ROSE_CS:
    assert property ($rose(host_data_lines_oe) |-> $past(chip_sel_n, 3) == 1'b0)
      else $error("drive start without cs");
  AST_HOLD:
    assert property (host_data_lines_oe && $past(host_data_lines_oe)
      |-> $stable(host_data_lines_out)) else $error("read byte moved");
  AST_IRQ:
    assert property (!$past(reset) |-> irq_n_oe == (|$past(chan_irq_pend)))
      else $error("irq line wrong");
  AST_IRQ_LOW:
    assert property (irq_n_oe |-> !irq_n_out) else $error("irq not low");
  AST_TX_VALID:
    assert property (!$past(reset) |-> (tx_byte_valid & ~$past(tx_pop)) == '0)
      else $error("valid without pop");
endmodule

// *** verification/tb.sv ***
// self-checking testbench of the host bus port
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic strap = 1'b1;
  logic [7:0] addr, bus, dout, q;
  logic rd_n, wr_n, cs_n, oe, irq_out, irq_oe;
  logic [7:0] pend = 8'h00, push = 8'h00, pop = 8'h00, valid;
  logic [7:0][7:0] rxb = '0, txb;
  int miscompares = 0;
  int n_checks = 0;
  always #25 core_clk = ~core_clk;
  ouhbp_host_model host (.clk(core_clk), .strap(strap), .addr(addr), .bus(bus),
    .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .dev_out(dout), .dev_oe(oe));
  ouhbp_host_port ouhbp_host_port_inst (.core_clk(core_clk), .reset(reset),
    .bus_style_strap(strap), .host_addr_lines(addr), .host_data_lines_in(bus),
    .host_data_lines_out(dout), .host_data_lines_oe(oe), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .chip_sel_n(cs_n), .irq_n_out(irq_out), .irq_n_oe(irq_oe),
    .chan_irq_pend(pend), .rx_push(push), .rx_byte(rxb), .tx_pop(pop),
    .tx_byte(txb), .tx_byte_valid(valid));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d, q);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic t_rx;
    rxb[3] = 8'hC5;
    push = 8'h08;
    @(negedge core_clk);
    rxb[3] = 8'h3A;
    @(negedge core_clk);
    push = 8'h00;
    rd(8'h3F, 8'h02);
    rd(8'h30, 8'hC5);
    rd(8'h3F, 8'h01);
    rd(8'h2F, 8'h00);
    rd(8'h35, 8'h00);
  endtask
  task automatic t_tx;
    wr(8'h50, 8'h96);
    wr(8'hD0, 8'h11);
    rd(8'h5E, 8'h01);
    pop = 8'h20;
    @(negedge core_clk);
    pop = 8'h00;
    chk(txb[5], 8'h96);
    chk(valid, 8'h20);
    rd(8'h5E, 8'h00);
  endtask
  task automatic t_irq;
    pend = 8'h81;
    rd(8'h80, 8'h81);
    chk({7'h00, irq_oe}, 8'h01);
    chk({7'h00, irq_out}, 8'h00);
    pend = 8'h00;
    rd(8'h8E, 8'h00);
    chk({7'h00, irq_oe}, 8'h00);
  endtask
  task automatic t_full;
    rxb[0] = 8'h77;
    push = 8'h01;
    repeat (66) @(negedge core_clk);
    push = 8'h00;
    rd(8'h0F, 8'h40);
    rd(8'h0E, 8'h00);
    reset = 1'b1;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    chk(txb[5], 8'h00);
    chk({7'h00, oe}, 8'h00);
    rd(8'h0F, 8'h00);
  endtask
  task automatic t_dir;
    strap = 1'b0;
    rxb[7] = 8'hE1;
    push = 8'h80;
    @(negedge core_clk);
    push = 8'h00;
    repeat (3) @(negedge core_clk);
    wr(8'h70, 8'h5A);
    rd(8'h7E, 8'h01);
    rd(8'h70, 8'hE1);
  endtask
  initial begin
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    repeat (3) @(negedge core_clk);
    t_rx;
    t_tx;
    t_irq;
    t_full;
    t_dir;
    print_verdict;
  end
  initial begin
    #100000;
    miscompares++;
    print_verdict;
  end
endmodule
bind ouhbp_host_port ouhbp_sva #(.NCH(NCH)) ouhbp_sva_inst (.core_clk(core_clk),
  .reset(reset), .bus_style_strap(bus_style_strap), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .chip_sel_n(chip_sel_n),
  .host_data_lines_out(host_data_lines_out), .host_data_lines_oe(host_data_lines_oe),
  .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .chan_irq_pend(chan_irq_pend),
  .tx_pop(tx_pop), .tx_byte_valid(tx_byte_valid));
